/* logic/jhv_pkg.sv */
package jhv_pkg;
  // wishbone word offsets (byte addresses)
  localparam logic [3:0] OFS_VECTOR  = 4'h0;
  localparam logic [3:0] OFS_DATA    = 4'h4;
  localparam logic [3:0] OFS_CONTROL = 4'h8;
  localparam logic [3:0] OFS_STATUS  = 4'hC;
  // control register fields
  localparam int CTL_IRQ_ALLOW   = 0;
  localparam int CTL_WAIT_CLOCK  = 1;
  localparam int CTL_END_OF_DATA = 2;
  localparam logic [7:0] CTL_RESET = 8'h00;
  // interrupt source codes in vector bits 5:2
  localparam logic [3:0] SRC_NONE    = 4'h0;
  localparam logic [3:0] SRC_EOF     = 4'h1;
  localparam logic [3:0] SRC_RESPONSE_BYTE_RECEIVED   = 4'h2;
  localparam logic [3:0] SRC_RXFULL  = 4'h3;
  localparam logic [3:0] SRC_TXEMPTY = 4'h4;
  localparam logic [3:0] SRC_ARBLOST = 4'h5;
  localparam logic [3:0] SRC_CRCERR  = 4'h6;
  localparam logic [3:0] SRC_INVALID = 4'h7;
  localparam logic [3:0] SRC_WAKEUP  = 4'h8;
  localparam int NUM_SRC = 8;
  localparam int VEC_LSB = 2;
  localparam logic [7:0] DATA_RESET = 8'h00;
  typedef enum logic [1:0] {PWR_RUN, PWR_WAIT, PWR_STOP} jhv_pwr_t;
endpackage

/* logic/jhv_core.sv */
// Added by the designer: the address map and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module jhv_core
  import jhv_pkg::*;
#(
  parameter int RESTART_CYCLES = 16
) (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // wishbone slave
  input  wire logic       cyc_i,
  input  wire logic       stb_i,
  input  wire logic       we_i,
  input  wire logic [3:0] adr_i,
  input  wire logic [3:0] sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]     dat_o,
  output logic            ack_o,
  // byte-level link engine
  input  wire logic       rx_byte_valid_i,
  input  wire logic [7:0] rx_byte_i,
  input  wire logic       rx_is_ifr_i,
  input  wire logic       rx_eof_i,
  input  wire logic       rx_msg_ok_i,
  input  wire logic       rx_busy_i,
  input  wire logic       arb_lost_i,
  input  wire logic       crc_err_i,
  input  wire logic       symbol_err_i,
  input  wire logic       bus_active_i,
  input  wire logic       tx_active_i,
  input  wire logic       tx_byte_done_i,
  input  wire logic       tx_first_bit_i,
  output logic [7:0]      tx_shift_o,
  output logic            tx_load_o,
  output logic            tx_underrun_o,
  output logic            tx_allow_o,
  // cpu power control
  input  wire logic       wait_instr_i,
  input  wire logic       stop_instr_i,
  output logic            irq_o,
  output logic            nmi_o,
  output logic            wake_o
);
  import jhv_pkg::*;

  logic [7:0]      ctl_q;
  logic [7:0]      rx_shadow_q;
  logic [7:0]      tx_shadow_q;
  logic            tx_shadow_full_q;
  logic [NUM_SRC:1] pend_q;
  logic [3:0]      code;
  logic            vec_seen_q;
  logic [1:0]      vec_seen_src_q;
  jhv_pwr_t        pwr_q;
  logic            eof_seen_q;
  logic            stop_via_wait_q;
  logic            stop_in_rx_q;
  logic            stop_wake_q;
  logic            bus_prev_q;
  logic [$clog2(RESTART_CYCLES+1)-1:0] restart_q;
  logic            wake_set;
  logic            acc;
  logic            rd_vec;
  logic            rd_data;
  logic            wr_data;
  logic            wr_ctl;
  logic            eod_set;
  logic            underrun;

  assign acc     = cyc_i && stb_i && !ack_o;
  assign rd_vec  = acc && !we_i && adr_i == OFS_VECTOR;
  assign rd_data = acc && !we_i && adr_i == OFS_DATA;
  assign wr_data = acc && we_i && adr_i == OFS_DATA && sel_i[0];
  assign wr_ctl  = acc && we_i && adr_i == OFS_CONTROL && sel_i[0];
  assign eod_set = wr_ctl && dat_i[CTL_END_OF_DATA];
  // shifter finished, no new byte, frame not ended
  assign underrun = tx_byte_done_i && !tx_shadow_full_q && !ctl_q[CTL_END_OF_DATA]
                    && tx_active_i;

  always_comb begin
    code = SRC_NONE;
    for (int i = 1; i <= NUM_SRC; i++) begin
      if (pend_q[i]) begin
        code = 4'(i);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= acc;
      dat_o <= 32'h0000_0000;
      if (acc && !we_i) begin
        unique case (adr_i)
          // code shifted to bits 5:2, rest zero
          OFS_VECTOR:  dat_o <= {26'h000_0000, code, 2'b00};
          OFS_DATA:    dat_o <= {24'h00_0000, rx_shadow_q};
          OFS_CONTROL: dat_o <= {24'h00_0000, ctl_q};
          OFS_STATUS:  dat_o <= {28'h000_0000, tx_shadow_full_q, eof_seen_q, 2'(pwr_q)};
          default:     dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // control register; end-of-data self-clears when the frame ends
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_q <= CTL_RESET;
    end else if (wr_ctl) begin
      ctl_q <= dat_i[7:0];
    end else if (!tx_active_i && !tx_shadow_full_q) begin
      ctl_q[CTL_END_OF_DATA] <= 1'b0;
    end
  end

  // remember which service-needing source the last vector read reported
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vec_seen_q     <= 1'b0;
      vec_seen_src_q <= 2'd0;
    end else if (rd_vec) begin
      vec_seen_q     <= 1'b1;
      vec_seen_src_q <= (code == SRC_TXEMPTY) ? 2'd2
                        : (code == SRC_RXFULL || code == SRC_RESPONSE_BYTE_RECEIVED) ? 2'd1 : 2'd0;
    end else if (rd_data || wr_data) begin
      vec_seen_q <= 1'b0;
    end
  end

  // pending flags; a set in the same cycle as its clear wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_q <= '0;
    end else begin
      // read clears reported source other than data-service ones
      if (rd_vec && code != SRC_NONE && code != SRC_RXFULL && code != SRC_RESPONSE_BYTE_RECEIVED
          && code != SRC_TXEMPTY) begin
        pend_q[code] <= 1'b0;
      end
      if (rd_data && vec_seen_q && vec_seen_src_q == 2'd1) begin
        pend_q[SRC_RXFULL] <= 1'b0;
        pend_q[SRC_RESPONSE_BYTE_RECEIVED]  <= 1'b0;
      end
      // vector read then data write, or end-of-data
      if ((wr_data && vec_seen_q && vec_seen_src_q == 2'd2) || eod_set) begin
        pend_q[SRC_TXEMPTY] <= 1'b0;
      end
      if (rx_eof_i) pend_q[SRC_EOF] <= 1'b1;
      if (rx_byte_valid_i && !rx_is_ifr_i) pend_q[SRC_RXFULL] <= 1'b1;
      if (rx_byte_valid_i && rx_is_ifr_i) pend_q[SRC_RESPONSE_BYTE_RECEIVED] <= 1'b1;
      // empty after first bit of loaded byte
      if (tx_first_bit_i && !tx_shadow_full_q && !ctl_q[CTL_END_OF_DATA]) begin
        pend_q[SRC_TXEMPTY] <= 1'b1;
      end
      if (arb_lost_i) pend_q[SRC_ARBLOST] <= 1'b1;
      if (crc_err_i) pend_q[SRC_CRCERR] <= 1'b1;
      // aborted frame reads back as invalid symbol
      if (symbol_err_i || underrun) pend_q[SRC_INVALID] <= 1'b1;
      if (wake_set) pend_q[SRC_WAKEUP] <= 1'b1;
    end
  end

  // receive shadow
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_shadow_q <= DATA_RESET;
    end else if (rx_byte_valid_i) begin
      rx_shadow_q <= rx_byte_i;
    end
  end

  // transmit shadow and shifter hand-off
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_shadow_q      <= DATA_RESET;
      tx_shadow_full_q <= 1'b0;
      tx_shift_o       <= DATA_RESET;
      tx_load_o        <= 1'b0;
    end else begin
      tx_load_o <= 1'b0;
      // move shadow into shifter when the byte is done
      if (tx_byte_done_i && tx_shadow_full_q) begin
        tx_shift_o       <= tx_shadow_q;
        tx_load_o        <= 1'b1;
        tx_shadow_full_q <= 1'b0;
      end
      if (wr_data) begin
        tx_shadow_q      <= dat_i[7:0];
        tx_shadow_full_q <= 1'b1;
      end
    end
  end

  // underrun: stop driving after two extra ones past the byte boundary
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_underrun_o <= 1'b0;
    end else if (underrun) begin
      // engine appends two ones then releases the bus
      tx_underrun_o <= 1'b1;
    end else if (!tx_active_i) begin
      tx_underrun_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      eof_seen_q <= 1'b0;
    end else if (rx_eof_i) begin
      eof_seen_q <= 1'b1;
    end else if (rx_busy_i) begin
      eof_seen_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_prev_q <= 1'b0;
    end else begin
      bus_prev_q <= bus_active_i;
    end
  end

  // power-mode machine
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwr_q           <= PWR_RUN;
      stop_via_wait_q <= 1'b0;
      stop_in_rx_q    <= 1'b0;
      restart_q       <= '0;
      wake_set        <= 1'b0;
      stop_wake_q     <= 1'b0;
    end else begin
      wake_set    <= 1'b0;
      stop_wake_q <= 1'b0;
      if (restart_q != '0) restart_q <= restart_q - 1'b1;
      unique case (pwr_q)
        PWR_RUN: begin
          // stop, or wait with wait-clock-mode set
          if (stop_instr_i || (wait_instr_i && ctl_q[CTL_WAIT_CLOCK])) begin
            pwr_q           <= PWR_STOP;
            stop_via_wait_q <= !stop_instr_i && eof_seen_q;
            stop_in_rx_q    <= rx_busy_i;
          end else if (wait_instr_i) begin
            pwr_q <= PWR_WAIT;
          end
        end
        PWR_WAIT: begin
          if (rx_msg_ok_i) begin
            pwr_q    <= PWR_RUN;
            wake_set <= 1'b1;
          end
        end
        PWR_STOP: begin
          // passive-to-active edge only, also when stopped mid-frame
          if (bus_active_i && !bus_prev_q) begin
            pwr_q       <= PWR_RUN;
            wake_set    <= 1'b1;
            stop_wake_q <= 1'b1;
            // clean byte only after eof-prior wait entry
            restart_q <= stop_via_wait_q ? '0
                         : ($clog2(RESTART_CYCLES+1))'(RESTART_CYCLES);
          end
        end
        default: pwr_q <= PWR_RUN;
      endcase
    end
  end

  // outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o      <= 1'b0;
      nmi_o      <= 1'b0;
      wake_o     <= 1'b0;
      tx_allow_o <= 1'b0;
    end else begin
      // maskable request gated by irq allow
      irq_o  <= ctl_q[CTL_IRQ_ALLOW] && pend_q != '0;
      // stop wake-up is non-maskable
      // every stop wake-up pulses it, held on through a clock restart
      nmi_o  <= stop_wake_q || (nmi_o && restart_q != '0);
      wake_o <= wake_set;
      // no drive in wait or stop; nor during clock restart
      // muted in the very cycle the underrun is flagged
      tx_allow_o <= pwr_q == PWR_RUN && restart_q == '0 && !stop_wake_q
                    && !underrun && !tx_underrun_o;
    end
  end
endmodule
`default_nettype wire

/* sim/jhv_core_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module jhv_core_asserts
  import jhv_pkg::*;
(
  // bus side
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [3:0]  adr_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  // link side
  input wire logic        tx_byte_done_i,
  input wire logic        tx_active_i,
  input wire logic        tx_load_o,
  input wire logic        tx_underrun_o,
  input wire logic        tx_allow_o,
  input wire logic        nmi_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_ack_next_edge: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("no ack after request");
  chk_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  chk_vec_zero_bits: assert property (ack_o && !we_i && adr_i == OFS_VECTOR |->
    dat_o[31:6] == 26'h0 && dat_o[1:0] == 2'h0) else $error("vector spare bits set");
  chk_vec_code_range: assert property (ack_o && !we_i && adr_i == OFS_VECTOR |->
    dat_o[5:2] <= SRC_WAKEUP) else $error("vector code out of range");
  chk_load_after_done: assert property (tx_load_o |-> $past(tx_byte_done_i))
    else $error("load without finished byte");
  chk_underrun_cause: assert property ($rose(tx_underrun_o) |->
    $past(tx_byte_done_i) && $past(tx_active_i)) else $error("underrun without cause");
  chk_underrun_mute: assert property (tx_underrun_o |-> !tx_allow_o)
    else $error("drive allowed in underrun");
  chk_restart_mute: assert property (nmi_o |-> !tx_allow_o)
    else $error("drive allowed in restart");
endmodule
bind jhv_core jhv_core_asserts i_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
  .dat_o, .ack_o, .tx_byte_done_i, .tx_active_i, .tx_load_o, .tx_underrun_o,
  .tx_allow_o, .nmi_o);
`default_nettype wire

/* sim/jhv_link_model.sv */
`timescale 1ns/1ps
`default_nettype none
module jhv_link_model (
  // design side
  input  wire logic       clk_i,
  input  wire logic       tx_load_i,
  input  wire logic [7:0] tx_shift_i,
  input  wire logic       tx_underrun_i,
  // link events
  output logic            rx_byte_valid_o,
  output logic [7:0]      rx_byte_o,
  output logic            rx_is_ifr_o,
  output logic            tx_active_o,
  output logic            tx_byte_done_o,
  output logic            tx_first_bit_o
);
  logic [7:0] cnt_q = 8'h00;
  logic [7:0] sent_q = 8'h00;
  logic       kick_q = 1'b0;
  initial begin
    {rx_byte_valid_o, rx_is_ifr_o, tx_active_o, tx_byte_done_o, tx_first_bit_o} = '0;
    rx_byte_o = 8'h00;
  end
  always @(posedge clk_i) begin
    tx_first_bit_o <= cnt_q == 8'd18;
    tx_byte_done_o <= kick_q || cnt_q == 8'd1;
    tx_active_o <= tx_load_i || (tx_active_o && !tx_underrun_i);
    if (tx_load_i) begin
      cnt_q <= 8'd20;
      sent_q <= tx_shift_i;
    end else if (cnt_q != 8'h00) begin
      cnt_q <= cnt_q - 8'd1;
    end
  end
  task automatic start_tx;
    @(posedge clk_i);
    kick_q <= 1'b1;
    @(posedge clk_i);
    kick_q <= 1'b0;
  endtask
  task automatic rx_put(input logic [7:0] b, input logic ifr);
    @(posedge clk_i);
    rx_byte_valid_o <= 1'b1;
    rx_byte_o <= b;
    rx_is_ifr_o <= ifr;
    @(posedge clk_i);
    rx_byte_valid_o <= 1'b0;
    rx_byte_o <= ~b;
  endtask
endmodule
`default_nettype wire

/* sim/jhv_core_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin err_total++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module jhv_core_tb_top;
  import jhv_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, bus_act = 0;
  logic wake_seen = 0, nmi_seen = 0;
  logic [3:0] adr = 4'h0;
  logic [31:0] dat = 32'h0000_0000, q;
  logic [6:0] ev = 7'h00;
  logic [7:0] walk [5] = '{8'h1C, 8'h18, 8'h14, 8'h04, 8'h00};
  int err_total = 0, checks_done = 0, cyc_cnt = 0;
  wire logic [31:0] dat_o;
  wire logic [7:0] rxb, txs;
  wire logic ack_o, rxv, rxi, txa, txd, txf, txl, txu, txo, irq_o, nmi_o, wake_o;
  jhv_core #(.RESTART_CYCLES(16)) i_dut (.clk_i, .rst_i, .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(dat), .dat_o, .ack_o,
    .rx_byte_valid_i(rxv), .rx_byte_i(rxb), .rx_is_ifr_i(rxi), .rx_eof_i(ev[0]),
    .rx_msg_ok_i(ev[4]), .rx_busy_i(1'b0), .arb_lost_i(ev[1]), .crc_err_i(ev[2]),
    .symbol_err_i(ev[3]), .bus_active_i(bus_act), .tx_active_i(txa),
    .tx_byte_done_i(txd), .tx_first_bit_i(txf), .tx_shift_o(txs), .tx_load_o(txl),
    .tx_underrun_o(txu), .tx_allow_o(txo), .wait_instr_i(ev[5]),
    .stop_instr_i(ev[6]), .irq_o, .nmi_o, .wake_o);
  jhv_link_model i_link (.clk_i, .tx_load_i(txl), .tx_shift_i(txs),
    .tx_underrun_i(txu), .rx_byte_valid_o(rxv), .rx_byte_o(rxb), .rx_is_ifr_o(rxi),
    .tx_active_o(txa), .tx_byte_done_o(txd), .tx_first_bit_o(txf));
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  task automatic finish_test;
    $display("errors %0d checks %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (wake_o === 1'b1) wake_seen <= 1'b1;
    if (nmi_o === 1'b1) nmi_seen <= 1'b1;
    if (cyc_cnt == 20000) begin
      err_total++;
      finish_test();
    end
  end
  // classic single cycle, waits for ack
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, 24'h00_0000, d};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o;
    {cyc, stb} <= 2'b00;
  endtask
  task automatic pulse(input logic [6:0] m);
    @(posedge clk_i);
    ev <= m;
    @(posedge clk_i);
    ev <= 7'h00;
  endtask
  task automatic vec(input logic [7:0] e);
    wb(0, OFS_VECTOR, 8'h00);
    `CHK("vector", e, q[7:0])
  endtask
  task automatic rdd(input logic [3:0] a, input logic [7:0] e);
    wb(0, a, 8'h00);
    `CHK("register", e, q[7:0])
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    pulse(7'h0F);
    foreach (walk[i]) vec(walk[i]);
    i_link.rx_put(8'h5A, 1'b0);
    vec(8'h0C);
    vec(8'h0C);
    rdd(OFS_DATA, 8'h5A);
    vec(8'h00);
    i_link.rx_put(8'h33, 1'b1);
    vec(8'h08);
    rdd(OFS_DATA, 8'h33);
    vec(8'h00);
    i_link.rx_put(8'h11, 1'b0);
    i_link.rx_put(8'h22, 1'b0);
    vec(8'h0C);
    rdd(OFS_DATA, 8'h22);
    wb(1, OFS_DATA, 8'hA5);
    i_link.start_tx();
    repeat (8) @(posedge clk_i);
    `CHK("sent", 8'hA5, i_link.sent_q)
    vec(8'h10);
    wb(1, OFS_DATA, 8'h3C);
    vec(8'h00);
    repeat (60) @(posedge clk_i);
    `CHK("sent", 8'h3C, i_link.sent_q)
    vec(8'h1C);
    vec(8'h10);
    wb(1, OFS_CONTROL, 8'h04);
    vec(8'h00);
    wb(1, OFS_CONTROL, 8'h01);
    pulse(7'h20);
    // status: eof seen (bit2) stays set, mode in bits 1:0
    rdd(OFS_STATUS, 8'h05);
    `CHK("drive", 1'b0, txo)
    pulse(7'h10);
    repeat (3) @(posedge clk_i);
    `CHK("irq", 1'b1, irq_o)
    vec(8'h20);
    wb(1, OFS_CONTROL, 8'h02);
    pulse(7'h20);
    rdd(OFS_STATUS, 8'h06);
    pulse(7'h00);
    bus_act <= 1'b1;
    repeat (40) @(posedge clk_i);
    `CHK("wake", 1'b1, wake_seen)
    `CHK("nmi", 1'b1, nmi_seen)
    bus_act <= 1'b0;
    pulse(7'h40);
    rdd(OFS_STATUS, 8'h06);
    bus_act <= 1'b1;
    repeat (3) @(posedge clk_i);
    `CHK("nmi restart", 1'b1, nmi_o)
    `CHK("restart drive", 1'b0, txo)
    repeat (40) @(posedge clk_i);
    `CHK("nmi", 1'b1, nmi_seen)
    finish_test();
  end
endmodule
`default_nettype wire
